// >>> verilog/hrr_pkg.sv
// Constants and types shared by the permanent row repair sequencer
package hrr_pkg;
	localparam int unsigned HRR_CLK_MHZ        = 125;
	localparam int unsigned HRR_CLK_KHZ        = HRR_CLK_MHZ * 1000;
	localparam int unsigned HRR_PGM_X48_MS     = 1000;
	localparam int unsigned HRR_PGM_X16_MS     = 2000;
	localparam int unsigned HRR_PGM_X48_CYC    = HRR_PGM_X48_MS * HRR_CLK_KHZ;
	localparam int unsigned HRR_PGM_X16_CYC    = HRR_PGM_X16_MS * HRR_CLK_KHZ;
	localparam int unsigned HRR_PGM_EXIT_NS    = 15;
	localparam int unsigned HRR_PGM_EXIT_CYC   =
		(HRR_PGM_EXIT_NS * HRR_CLK_MHZ + 999) / 1000;
	localparam int unsigned HRR_MODE_EXIT_US   = 50;
	localparam int unsigned HRR_MODE_EXIT_CYC  = HRR_MODE_EXIT_US * HRR_CLK_MHZ;
	localparam int unsigned HRR_PGM_W          = 28;
	localparam int unsigned HRR_EXIT_W         = 13;
	// Command codes on the decoded command port
	localparam logic [2:0] HRR_CMD_NOP = 3'h0;
	localparam logic [2:0] HRR_CMD_MRS = 3'h1;
	localparam logic [2:0] HRR_CMD_ACT = 3'h2;
	localparam logic [2:0] HRR_CMD_WR  = 3'h3;
	localparam logic [2:0] HRR_CMD_WRA = 3'h4;
	localparam logic [2:0] HRR_CMD_RD  = 3'h5;
	localparam logic [2:0] HRR_CMD_PRE = 3'h6;
	localparam logic [2:0] HRR_CMD_REF = 3'h7;
	// Mode register select {bg0, ba1, ba0}
	localparam logic [2:0] HRR_MRSEL_GUARD  = 3'h0;
	localparam logic [2:0] HRR_MRSEL_REPAIR = 3'h4;
	localparam int unsigned HRR_PERM_BIT = 13;
	localparam int unsigned HRR_TEMP_BIT = 5;
	localparam logic [6:0] HRR_KEY_LOW = 7'h7F;
	localparam logic [4:0] HRR_KEY0 = 5'h19;
	localparam logic [4:0] HRR_KEY1 = 5'h0F;
	localparam logic [4:0] HRR_KEY2 = 5'h17;
	localparam logic [4:0] HRR_KEY3 = 5'h07;
	localparam logic [5:0] HRR_WL_MIN = 6'h02;
	// Register map
	localparam logic [3:0] HRR_OFS_CTRL   = 4'h0;
	localparam logic [3:0] HRR_OFS_STATUS = 4'h4;
	localparam logic [3:0] HRR_OFS_COUNT  = 4'h8;
	localparam logic [5:0] HRR_CTRL_WL_RST  = 6'h0C;
	localparam int unsigned HRR_CTRL_X16_BIT = 8;
	localparam int unsigned HRR_ST_VIOL_BIT  = 5;
	typedef enum logic [2:0] {
		HRR_RES_NONE, HRR_RES_DONE, HRR_RES_SKIP, HRR_RES_UNDEF,
		HRR_RES_NORES, HRR_RES_EARLY
	} hrr_result_type;
	typedef enum logic [2:0] {
		ST_IDLE, ST_KEY, ST_ARMED, ST_ACT, ST_WLAT, ST_CAP, ST_PGM, ST_EXIT
	} hrr_state_type;
endpackage

// >>> verilog/hrr_fuse_mem.sv
// Per-bank permanent repair store; a used entry cannot be rewritten until reset clears its used flag
`timescale 1ns/100ps
module hrr_fuse_mem
	import hrr_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	input  wire logic [3:0]  rd_addr,
	output logic      [18:0] rd_data,
	input  wire logic        wr_en,
	input  wire logic [3:0]  wr_addr,
	input  wire logic [17:0] wr_row
);
	logic [15:0] used_reg;
	logic [17:0] row_mem [16];

	genvar g;
	generate
		for (g = 0; g < 16; g++) begin : g_bank
			always_ff @(posedge clk_sys or negedge rstn) begin
				if (!rstn)
					used_reg[g] <= 1'b0;
				else if (wr_en && wr_addr == 4'(g))
					used_reg[g] <= 1'b1;
			end
			always_ff @(posedge clk_sys) begin
				if (wr_en && wr_addr == 4'(g) && !used_reg[g])
					row_mem[g] <= wr_row;
			end
		end
	endgenerate

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			rd_data <= 19'h00000;
		else
			rd_data <= {used_reg[rd_addr], row_mem[rd_addr]};
	end
endmodule

// >>> verilog/hrr_sequencer.sv
// Permanent row repair sequencer inside the memory device
// Operation
// - Repair register bit 13 enters and leaves mode
// - Autoprecharge form keeps data; plain write doesn't
// - Enable drives every DQ output high
// - Bad or interrupted keys leave repair unarmed
// - After failed keys, activate and write act normally
// - Repair only if all eight beats low
// - High two clocks skips; else outcome undefined
// - Refresh all banks except the repaired one
// - Bank without repair resource ignores whole sequence; code runs it but skips the fuse write
// - A permanent repair is never overwritten; code clears the used flags on reset, so a bank can be repaired again
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
module hrr_sequencer
	import hrr_pkg::*;
#(
	parameter int unsigned PGM_X48_CYC   = HRR_PGM_X48_CYC,
	parameter int unsigned PGM_X16_CYC   = HRR_PGM_X16_CYC,
	parameter int unsigned MODE_EXIT_CYC = HRR_MODE_EXIT_CYC
)(
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	input  wire logic        cmd_valid,
	input  wire logic [2:0]  cmd_code,
	input  wire logic [1:0]  cmd_bg,
	input  wire logic [1:0]  cmd_ba,
	input  wire logic [17:0] cmd_addr,
	input  wire logic [7:0]  dq_rise,
	input  wire logic [7:0]  dq_fall,
	output logic      [7:0]  dq_out,
	output logic             dq_oe,
	output logic      [15:0] refresh_banks,
	output logic             array_cmd_pass,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata
);
	function automatic logic [3:0] bank_idx(logic [1:0] bg, logic [1:0] ba);
		return {bg, ba};
	endfunction

	hrr_state_type  state_reg;
	hrr_result_type result_reg;
	logic                  mode_en_reg, temp_seen_reg, viol_reg, wra_form_reg;
	logic [1:0]            key_idx_reg, beat_reg, high_run_reg;
	logic                  low_ok_reg, go_reg;
	logic [3:0]            tgt_bank_reg;
	logic [17:0]           tgt_row_reg;
	logic [5:0]            wl_reg, wl_cnt_reg;
	logic                  x16_reg;
	logic [HRR_PGM_W-1:0]  pgm_cnt_reg;
	logic [HRR_EXIT_W-1:0] exit_cnt_reg;
	logic [1:0]            pre_cnt_reg;
	logic [4:0]            count_reg;
	logic [18:0]           fuse_rd;
	logic mrs, mr4_wr, mr4_on, mr4_off, key_hit, pgm_done, commit, viol_set;
	logic [4:0] key_want;

	assign mrs     = cmd_valid && cmd_code == HRR_CMD_MRS;
	assign mr4_wr  = mrs && {cmd_bg[0], cmd_ba} == HRR_MRSEL_REPAIR;
	assign mr4_on  = mr4_wr && cmd_addr[HRR_PERM_BIT];
	assign mr4_off = mr4_wr && !cmd_addr[HRR_PERM_BIT];
	always_comb begin
		case (key_idx_reg)
			2'h0:    key_want = HRR_KEY0;
			2'h1:    key_want = HRR_KEY1;
			2'h2:    key_want = HRR_KEY2;
			default: key_want = HRR_KEY3;
		endcase
	end
	assign key_hit = mrs && cmd_bg == 2'h0 && cmd_ba == 2'h0 &&
		cmd_addr[6:0] == HRR_KEY_LOW && cmd_addr[11:7] == key_want;
	assign pgm_done = pgm_cnt_reg == (x16_reg ? HRR_PGM_W'(PGM_X16_CYC)
		: HRR_PGM_W'(PGM_X48_CYC));
	// Commit needs a clean low burst, full burn time and a free bank
	assign commit = state_reg == ST_PGM && cmd_valid &&
		cmd_code == HRR_CMD_PRE && go_reg && pgm_done && !fuse_rd[18];
	assign viol_set = cmd_valid && (exit_cnt_reg != '0 ||
		(state_reg == ST_EXIT && pre_cnt_reg != 2'h0) ||
		(cmd_code == HRR_CMD_REF && state_reg == ST_PGM
		 && !wra_form_reg));

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_reg   <= ST_IDLE;
			mode_en_reg <= 1'b0;
			key_idx_reg <= 2'h0;
		end else if (mr4_off) begin
			state_reg   <= ST_IDLE;
			mode_en_reg <= 1'b0;
		end else begin
			case (state_reg)
				ST_IDLE: if (mr4_on && !mode_en_reg) begin
					mode_en_reg <= 1'b1;
					state_reg   <= ST_KEY;
					key_idx_reg <= 2'h0;
				end
				ST_KEY: if (cmd_valid) begin
					if (key_hit) begin
						key_idx_reg <= key_idx_reg + 2'h1;
						if (key_idx_reg == 2'h3)
							state_reg <= ST_ARMED;
					end else
						state_reg <= ST_IDLE;
				end
				ST_ARMED: if (cmd_valid)
					state_reg <= cmd_code == HRR_CMD_ACT ? ST_ACT : ST_IDLE;
				ST_ACT: if (cmd_valid) begin
					if ((cmd_code == HRR_CMD_WR || cmd_code == HRR_CMD_WRA) &&
						bank_idx(cmd_bg, cmd_ba) == tgt_bank_reg)
						state_reg <= ST_WLAT;
					else
						state_reg <= ST_IDLE;
				end
				ST_WLAT: if (wl_cnt_reg <= HRR_WL_MIN)
					state_reg <= ST_CAP;
				ST_CAP: if (beat_reg == 2'h3)
					state_reg <= ST_PGM;
				ST_PGM: if (cmd_valid && cmd_code == HRR_CMD_PRE)
					state_reg <= ST_EXIT;
				ST_EXIT: state_reg <= ST_EXIT;
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// Target capture, latency count and DQ burst judgement
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			tgt_bank_reg <= 4'h0;
			tgt_row_reg  <= 18'h00000;
			wra_form_reg <= 1'b0;
			wl_cnt_reg   <= 6'h00;
			beat_reg     <= 2'h0;
			low_ok_reg   <= 1'b0;
			high_run_reg <= 2'h0;
			go_reg       <= 1'b0;
		end else begin
			if (state_reg == ST_ARMED && cmd_valid) begin
				tgt_bank_reg <= bank_idx(cmd_bg, cmd_ba);
				tgt_row_reg  <= cmd_addr;
			end
			if (state_reg == ST_ACT && cmd_valid) begin
				wra_form_reg <= cmd_code == HRR_CMD_WRA;
				wl_cnt_reg   <= wl_reg;
				beat_reg     <= 2'h0;
				low_ok_reg   <= 1'b1;
				high_run_reg <= 2'h0;
				go_reg       <= 1'b0;
			end else if (state_reg == ST_WLAT)
				wl_cnt_reg <= wl_cnt_reg - 6'h01;
			if (state_reg == ST_CAP) begin
				beat_reg <= beat_reg + 2'h1;
				if (dq_rise != 8'h00 || dq_fall != 8'h00)
					low_ok_reg <= 1'b0;
				if (beat_reg < 2'h2 && high_run_reg == beat_reg &&
					dq_rise == 8'hFF && dq_fall == 8'hFF)
					high_run_reg <= high_run_reg + 2'h1;
				if (beat_reg == 2'h3)
					go_reg <= low_ok_reg && dq_rise == 8'h00 &&
						dq_fall == 8'h00;
			end
		end
	end

	// Programming, precharge exit and mode exit timers
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pgm_cnt_reg  <= '0;
			pre_cnt_reg  <= 2'h0;
			exit_cnt_reg <= '0;
		end else begin
			if (state_reg != ST_PGM)
				pgm_cnt_reg <= '0;
			else if (!pgm_done)
				pgm_cnt_reg <= pgm_cnt_reg + 1'b1;
			if (state_reg == ST_PGM && cmd_valid && cmd_code == HRR_CMD_PRE)
				pre_cnt_reg <= 2'(HRR_PGM_EXIT_CYC);
			else if (pre_cnt_reg != 2'h0)
				pre_cnt_reg <= pre_cnt_reg - 2'h1;
			if (mr4_off && mode_en_reg)
				exit_cnt_reg <= HRR_EXIT_W'(MODE_EXIT_CYC);
			else if (exit_cnt_reg != '0)
				exit_cnt_reg <= exit_cnt_reg - 1'b1;
		end
	end

	// Outcome record
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			result_reg <= HRR_RES_NONE;
			count_reg  <= 5'h00;
		end else if (state_reg == ST_PGM && cmd_valid &&
			cmd_code == HRR_CMD_PRE) begin
			if (commit) begin
				result_reg <= HRR_RES_DONE;
				count_reg  <= count_reg + 5'h01;
			end else if (fuse_rd[18])
				result_reg <= HRR_RES_NORES;
			else if (!go_reg)
				result_reg <= high_run_reg == 2'h2 ? HRR_RES_SKIP
					: HRR_RES_UNDEF;
			else
				result_reg <= HRR_RES_EARLY;
		end
	end

	// DQ held high while in mode, released for the write burst
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			dq_out <= 8'h00;
			dq_oe  <= 1'b0;
		end else begin
			dq_out <= 8'hFF;
			dq_oe  <= (mode_en_reg || mr4_on) && !mr4_off &&
				state_reg != ST_WLAT && state_reg != ST_CAP &&
				!(state_reg == ST_ACT && cmd_valid);
		end
	end

	// Refresh and ordinary command pass-through
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			refresh_banks  <= 16'h0000;
			array_cmd_pass <= 1'b0;
		end else begin
			refresh_banks <= 16'h0000;
			if (cmd_valid && cmd_code == HRR_CMD_REF) begin
				if (!mode_en_reg || state_reg == ST_IDLE)
					refresh_banks <= 16'hFFFF;
				else if (state_reg == ST_PGM && wra_form_reg)
					refresh_banks <= ~(16'h0001 << tgt_bank_reg);
			end
			array_cmd_pass <= cmd_valid && !mrs &&
				(!mode_en_reg || state_reg == ST_IDLE);
		end
	end

	// Register port
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			wl_reg        <= HRR_CTRL_WL_RST;
			x16_reg       <= 1'b0;
			viol_reg      <= 1'b0;
			temp_seen_reg <= 1'b0;
			reg_rdata     <= 32'h00000000;
		end else begin
			if (reg_wr && reg_addr == HRR_OFS_CTRL) begin
				wl_reg  <= reg_wdata[5:0];
				x16_reg <= reg_wdata[HRR_CTRL_X16_BIT];
			end
			// Set wins over a clear in the same cycle
			if (viol_set)
				viol_reg <= 1'b1;
			else if (reg_wr && reg_addr == HRR_OFS_STATUS)
				viol_reg <= 1'b0;
			if (mr4_wr)
				temp_seen_reg <= cmd_addr[HRR_TEMP_BIT];
			reg_rdata <= 32'h00000000;
			if (reg_rd) begin
				case (reg_addr)
					HRR_OFS_CTRL: reg_rdata <= {23'h0, x16_reg, 2'h0, wl_reg};
					HRR_OFS_STATUS: reg_rdata <= {21'h0, result_reg, 2'h0,
						viol_reg, exit_cnt_reg != '0, pgm_done,
						state_reg == ST_PGM, temp_seen_reg, mode_en_reg};
					HRR_OFS_COUNT: reg_rdata <= {27'h0, count_reg};
					default: reg_rdata <= 32'h00000000;
				endcase
			end
		end
	end

	hrr_fuse_mem u_fuse (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.rd_addr (tgt_bank_reg),
		.rd_data (fuse_rd),
		.wr_en   (commit),
		.wr_addr (tgt_bank_reg),
		.wr_row  (tgt_row_reg)
	);

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	logic cap_st;
	assign cap_st = state_reg == ST_CAP;

	property p_dq_high;
		mr4_on && !mode_en_reg |=> dq_oe && dq_out == 8'hFF;
	endproperty
	a_dq_high: assert property (p_dq_high) else $error("DQ not high");
	property p_key_fail;
		state_reg == ST_KEY && cmd_valid && !key_hit && !mr4_wr
			|=> state_reg == ST_IDLE;
	endproperty
	a_key_fail: assert property (p_key_fail) else $error("bad key kept");
	property p_arm_path;
		state_reg == ST_ARMED |-> $past(state_reg) inside {ST_KEY, ST_ARMED};
	endproperty
	a_arm_path: assert property (p_arm_path) else $error("armed w/o keys");
	property p_ordinary;
		cmd_valid && cmd_code == HRR_CMD_ACT && state_reg == ST_IDLE
			|=> array_cmd_pass;
	endproperty
	a_ordinary: assert property (p_ordinary) else $error("ACT dropped");
	property p_cap_len;
		$rose(cap_st) |-> cap_st [*4] ##1 !cap_st;
	endproperty
	a_cap_len: assert property (p_cap_len) else $error("burst length");
	property p_commit_low;
		commit |-> go_reg && $past(state_reg, 1) inside {ST_PGM, ST_CAP};
	endproperty
	a_commit_low: assert property (p_commit_low) else $error("bad commit");
	property p_ref_mask;
		refresh_banks != 16'hFFFF && refresh_banks != 16'h0000
			|-> !refresh_banks[tgt_bank_reg] && $countones(refresh_banks) == 15;
	endproperty
	a_ref_mask: assert property (p_ref_mask) else $error("ref mask");
	property p_no_overwrite;
		commit |-> !fuse_rd[18] && pgm_done;
	endproperty
	a_no_overwrite: assert property (p_no_overwrite) else $error("reuse");
	property p_exit;
		mr4_off |=> !mode_en_reg && state_reg == ST_IDLE && !dq_oe;
	endproperty
	a_exit: assert property (p_exit) else $error("exit failed");
	c_commit: cover property (commit);
	c_key_fail: cover property (state_reg == ST_KEY ##1 state_reg == ST_IDLE);
	c_ref: cover property (state_reg == ST_PGM && refresh_banks != 16'h0000);
endmodule

// >>> test/hrr_ctrl_model.sv
// Controller model that drives repair commands and DQ beats
`timescale 1ns/100ps
module hrr_ctrl_model
	import hrr_pkg::*;
#(
	parameter int unsigned WL   = 12,
	parameter int unsigned EXIT = 10
)(
	input  wire logic        clk_sys,
	output logic             cmd_valid,
	output logic      [2:0]  cmd_code,
	output logic      [1:0]  cmd_bg,
	output logic      [1:0]  cmd_ba,
	output logic      [17:0] cmd_addr,
	output logic      [7:0]  dq_rise,
	output logic      [7:0]  dq_fall
);
	// Every bank starts closed; DBI and CRC are never switched on
	initial begin
		cmd_valid = 1'b0;
		{cmd_code, cmd_bg, cmd_ba, cmd_addr} = 25'h0;
		{dq_fall, dq_rise} = 16'hA55A;
	end
	// Idle lines show the inverse so stale values never look valid
	task automatic cmd(input logic [2:0] c, input logic [1:0] g,
		input logic [1:0] b, input logic [17:0] a);
		@(posedge clk_sys);
		cmd_valid <= 1'b1;
		{cmd_code, cmd_bg, cmd_ba, cmd_addr} <= {c, g, b, a};
		@(posedge clk_sys);
		cmd_valid <= 1'b0;
		{cmd_code, cmd_bg, cmd_ba, cmd_addr} <= ~{c, g, b, a};
	endtask
	// Temporary repair bit always left at 0
	task automatic mode(input logic on);
		cmd(HRR_CMD_MRS, 2'h1, 2'h0, 18'(on) << HRR_PERM_BIT);
	endtask
	task automatic keys(input logic bad);
		logic [4:0] k [4];
		k = '{HRR_KEY0, HRR_KEY1, HRR_KEY2, HRR_KEY3};
		if (bad)
			k = '{HRR_KEY0, HRR_KEY2, HRR_KEY1, HRR_KEY3};
		foreach (k[i])
			cmd(HRR_CMD_MRS, 2'h0, 2'h0, {6'h00, k[i], HRR_KEY_LOW});
	endtask
	// Column bits are driven but carry no meaning
	task automatic act_wr(input logic [3:0] bank, input logic wra,
		input logic [17:0] row, input logic [63:0] p);
		cmd(HRR_CMD_ACT, bank[3:2], bank[1:0], row);
		cmd(wra ? HRR_CMD_WRA : HRR_CMD_WR, bank[3:2], bank[1:0], ~row);
		repeat (WL - 1) @(posedge clk_sys);
		for (int i = 0; i < 4; i++) begin
			{dq_fall, dq_rise} <= p[16*i +: 16];
			@(posedge clk_sys);
		end
		{dq_fall, dq_rise} <= ~p[63:48];
	endtask
	// One refresh per window keeps the quarter-interval spacing
	task automatic refresh();
		cmd(HRR_CMD_REF, 2'h0, 2'h0, 18'h0);
	endtask
	task automatic pre(input logic [3:0] bank);
		cmd(HRR_CMD_PRE, bank[3:2], bank[1:0], 18'h0);
		repeat (4) @(posedge clk_sys);
	endtask
	// Guard register put back to a plain setting after exit
	task automatic leave();
		mode(1'b0);
		repeat (EXIT + 4) @(posedge clk_sys);
		cmd(HRR_CMD_MRS, 2'h0, 2'h0, 18'h0);
	endtask
endmodule

// >>> test/hrr_sequencer_tb_top.sv
// Self-checking bench for the permanent row repair sequencer
`timescale 1ns/100ps
module hrr_sequencer_tb_top
	import hrr_pkg::*;
;
	localparam int unsigned PGM = 20;
	localparam int unsigned EXT = 10;
	logic        clk_sys;
	logic        rstn;
	logic        cmd_valid;
	logic [2:0]  cmd_code;
	logic [1:0]  cmd_bg;
	logic [1:0]  cmd_ba;
	logic [17:0] cmd_addr;
	logic [7:0]  dq_rise;
	logic [7:0]  dq_fall;
	logic [7:0]  dq_out;
	logic        dq_oe;
	logic [15:0] refresh_banks;
	logic        array_cmd_pass;
	logic [3:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic        rd_seen;
	logic [31:0] exp_q [$];
	logic [31:0] msk_q [$];
	int          miscompares;
	int          checks_done;
	int          seed;

	hrr_sequencer #(
		.PGM_X48_CYC  (PGM),
		.PGM_X16_CYC  (2 * PGM),
		.MODE_EXIT_CYC(EXT)
	) hrr_sequencer_i (
		.clk_sys, .rstn, .cmd_valid, .cmd_code, .cmd_bg, .cmd_ba,
		.cmd_addr, .dq_rise, .dq_fall, .dq_out, .dq_oe, .refresh_banks,
		.array_cmd_pass, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata
	);
	hrr_ctrl_model #(
		.WL  (int'(HRR_CTRL_WL_RST)),
		.EXIT(EXT)
	) hrr_ctrl_model_i (
		.clk_sys, .cmd_valid, .cmd_code, .cmd_bg, .cmd_ba, .cmd_addr,
		.dq_rise, .dq_fall
	);

	always #4 clk_sys = ~clk_sys;

	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		checks_done++;
		if (seen !== want) begin
			miscompares++;
			$display("[FAIL] %0t seen %h want %h", $time, seen, want);
		end
	endtask
	task automatic note(input string s);
		$display("%s test done at %0t", s, $time);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	// Expected value noted now, compared when the data stands
	task automatic rd(input logic [3:0] a, input logic [31:0] e,
		input logic [31:0] m);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		exp_q.push_back(e);
		msk_q.push_back(m);
		@(posedge clk_sys);
		reg_rd <= 1'b0;
	endtask
	always @(posedge clk_sys) begin
		rd_seen <= reg_rd;
		if (rd_seen && exp_q.size() == 0)
			miscompares++;
		else if (rd_seen)
			chk(reg_rdata & msk_q.pop_front(), exp_q.pop_front());
	end

	task automatic run(input logic [3:0] bank, input logic wra,
		input logic [63:0] p, input hrr_result_type res);
		hrr_ctrl_model_i.mode(1'b1);
		#1;
		chk(32'(dq_oe), 32'h1);
		chk(32'(dq_out), 32'hFF);
		hrr_ctrl_model_i.keys(1'b0);
		hrr_ctrl_model_i.act_wr(bank, wra, 18'($random(seed)), p);
		repeat (4) @(posedge clk_sys);
		hrr_ctrl_model_i.refresh();
		#1;
		// Plain form must refresh no bank at all
		chk(32'(refresh_banks),
			wra ? {16'h0, ~(16'h1 << bank)} : 32'h0);
		repeat (PGM) @(posedge clk_sys);
		hrr_ctrl_model_i.pre(bank);
		// Plain form must flag the refresh it was given
		rd(HRR_OFS_STATUS, {21'h0, res, 8'h0} | (32'(!wra) << 5),
			wra ? 32'h700 : 32'h720);
		wr(HRR_OFS_STATUS, 32'h0);
		hrr_ctrl_model_i.leave();
		#1;
		chk(32'(dq_oe), 32'h0);
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		#100000;
		miscompares++;
		finish_test();
	end

	initial begin
		clk_sys = 1'b0;
		rstn = 1'b0;
		{reg_addr, reg_wdata, reg_wr, reg_rd, rd_seen} = '0;
		miscompares = 0;
		checks_done = 0;
		seed = 26252;
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
		#1;
		chk(32'(dq_out), 32'hFF);
		chk(32'(dq_oe), 32'h0);
		rd(HRR_OFS_CTRL, 32'h0C, 32'h13F);
		rd(HRR_OFS_COUNT, 32'h0, 32'h1F);
		wr(4'hC, 32'hFFFFFFFF);
		rd(4'hC, 32'h0, 32'hFFFFFFFF);
		note("reset");
		run(4'h5, 1'b1, 64'h0, HRR_RES_DONE);
		rd(HRR_OFS_COUNT, 32'h1, 32'h1F);
		note("repair");
		run(4'h5, 1'b1, 64'h0, HRR_RES_NORES);
		run(4'h2, 1'b0, '1, HRR_RES_SKIP);
		run(4'h3, 1'b1, 64'h0000_0100_0000_0000, HRR_RES_UNDEF);
		note("outcome");
		// Longer programming time for the wide part
		wr(HRR_OFS_CTRL, 32'h10C);
		rd(HRR_OFS_CTRL, 32'h10C, 32'h13F);
		run(4'h7, 1'b1, 64'h0, HRR_RES_EARLY);
		wr(HRR_OFS_CTRL, 32'h0C);
		note("early precharge");
		hrr_ctrl_model_i.mode(1'b1);
		hrr_ctrl_model_i.keys(1'b1);
		hrr_ctrl_model_i.cmd(HRR_CMD_ACT, 2'h1, 2'h1, 18'($random(seed)));
		#1;
		chk(32'(array_cmd_pass), 32'h1);
		hrr_ctrl_model_i.cmd(HRR_CMD_WR, 2'h1, 2'h1, 18'h0);
		#1;
		chk(32'(array_cmd_pass), 32'h1);
		hrr_ctrl_model_i.pre(4'h5);
		hrr_ctrl_model_i.leave();
		rd(HRR_OFS_COUNT, 32'h1, 32'h1F);
		repeat (2) @(posedge clk_sys);
		note("broken keys");
		finish_test();
	end
endmodule
